// file: shared/asi_defines.svh
`ifndef ASI_DEFINES_SVH
`define ASI_DEFINES_SVH
// ==========================================================
// register byte offsets
`define ASI_OFF_GCFG 8'h00
`define ASI_OFF_CCTL 8'h04
`define ASI_OFF_ISTAT 8'h08
`define ASI_OFF_RXSC 8'h0C
`define ASI_OFF_TXSC 8'h10
`define ASI_OFF_TXFIFO 8'h14
`define ASI_OFF_RXFIFO 8'h18
`define ASI_OFF_TXDMA 8'h1C
`define ASI_OFF_RXDMA 8'h20
// ==========================================================
// reset values
`define ASI_RST_GCFG 32'h0000_0000
`define ASI_RST_CCTL 32'h0000_0F01
`define ASI_RST_LIMIT 4'h8
// ==========================================================
// field positions inside status and control words
`define ASI_SC_FLAG_BIT 0
`define ASI_IST_RXE_BIT 0
`define ASI_IST_RXP_BIT 1
`define ASI_IST_TXE_BIT 2
`define ASI_IST_TXP_BIT 3
// ==========================================================
// sizes and bit counts
`define ASI_PTR_W 4
`define ASI_WORD_W 16
`define ASI_FIFO_FULL_CNT 5'h10
`define ASI_WLEN_8 5'h08
`define ASI_WLEN_16 5'h10
`define ASI_FS_SHORT 5'h01
`define ASI_FSL_LEN_6 5'h06
`define ASI_FSL_LEN_13 5'h0D
`define ASI_FSL_LEN_14 5'h0E
`define ASI_FSL_LEN_15 5'h0F
`define ASI_FSL_LEN_16 5'h10
`endif

// file: shared/asi_pkg.sv
`include "asi_defines.svh"
package asi_pkg;
    // ======================================================
    // bus carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } asi_apb_req_type;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } asi_apb_rsp_type;
    // ======================================================
    // configuration images
    typedef enum logic [2:0] {
        ASI_FSL_6, ASI_FSL_13, ASI_FSL_14, ASI_FSL_15, ASI_FSL_16
    } asi_fsl_type;
    typedef enum logic {ASI_IDLE, ASI_SHIFT} asi_shift_type;
    typedef struct packed {
        logic [20:0] rsvd;
        logic rx_slot0_dma_select;
        logic tx_slot0_dma_select;
        logic ext_clock;
        asi_fsl_type frame_sync_length;
        logic long_sync;
        logic word16;
        logic clk_src;
        logic sync_mode;
        logic enable;
    } asi_gcfg_type;
    typedef struct packed {
        logic [16:0] rsvd;
        logic [6:0] frame_clock_divisor;
        logic [7:0] bit_clock_divisor;
    } asi_cctl_type;
    typedef struct packed {
        logic [3:0] limit;
        logic err_ie;
        logic warn_ie;
        logic err_flag;
    } asi_dirctl_type;
    typedef struct packed {
        logic [18:0] rsvd;
        logic dma_full;
        logic [4:0] count;
        asi_dirctl_type ctl;
    } asi_sc_img_type;
    typedef struct packed {
        logic [(1 << `ASI_PTR_W)-1:0][`ASI_WORD_W-1:0] mem;
        logic [`ASI_PTR_W-1:0] wptr;
        logic [`ASI_PTR_W-1:0] rptr;
        logic last_wr;
    } asi_fifo_state_type;
endpackage

// file: rtl/asi_fifo.sv
`timescale 1ns/100ps
`default_nettype none
`include "asi_defines.svh"
module asi_fifo
    import asi_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic push,
    input wire logic [`ASI_WORD_W-1:0] push_data,
    // drain side
    input wire logic pop,
    output logic [`ASI_WORD_W-1:0] rd_data,
    // fill level
    output logic [4:0] count,
    output logic empty,
    output logic full
);
    asi_fifo_state_type st;
    asi_fifo_state_type next_st;
    logic ptr_eq;

    // ======================================================
    // pointer stepping; overflow guarding is left to the user
    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.mem[st.wptr] = push_data;
            next_st.wptr = st.wptr + 4'h1;
        end
        if (pop)
        begin
            next_st.rptr = st.rptr + 4'h1;
        end
        if (push != pop)
        begin
            next_st.last_wr = push;
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    // equal pointers split by the last access direction
    assign ptr_eq = st.wptr == st.rptr;
    assign empty = ptr_eq && !st.last_wr;
    assign full = ptr_eq && st.last_wr;
    assign rd_data = st.mem[st.rptr];
    assign count = full ? `ASI_FIFO_FULL_CNT : {1'b0, st.wptr - st.rptr};
endmodule
`default_nettype wire

// file: rtl/asi_top.sv
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "asi_defines.svh"
// Summary of operation
// - bit clock is source over divisor plus one
// - software picks 12 or 48 MHz source
// - frame clock is bit clock over divisor+1
// - long sync lasts 6,13,14,15,16 bits
// - four sources merge to one interrupt
// - four pending flags: overrun, warn, underrun, warn
// - transmit frame sync routed to wakeup
// - one slot per frame, 8-bit uses low byte
// - each frame sync starts a transmit word
// - transmit bits leave on rising bit clock
// - dma transmit reloads, requests, resends when empty
// - transmit fifo pops and pushes advance pointers
// - transmit underrun resends, flags, mutes warning interrupt
// - transmit clock and sync internal or external
// - receive samples on falling bit clock
// - dma receive copies, requests, overwrites when full
// - receive fifo pushes and reads advance pointers
// - full receive fifo drops word, flags overrun
// - warning interrupts compare counts with limits
// - slot-0 select picks fifo or dma path
// - synchronous receive uses transmit clock and sync
// - word length 8 or 16 bits
module asi_top
    import asi_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // register bus
    input wire asi_apb_req_type apb_req,
    output var asi_apb_rsp_type apb_rsp,
    // prescaler source ticks, one cycle each
    input wire logic aux_tick,
    input wire logic pll_tick,
    // transmit bit clock pin
    input wire logic tx_bit_clock_in,
    output logic tx_bit_clock_out,
    output logic tx_bit_clock_oe,
    // transmit frame sync pin
    input wire logic tx_frame_sync_in,
    output logic tx_frame_sync_out,
    output logic tx_frame_sync_oe,
    // receive clock and sync pins
    input wire logic rx_bit_clock,
    input wire logic rx_frame_sync,
    // serial data pins
    input wire logic serial_rx_data,
    output logic serial_tx_data,
    output logic serial_tx_data_oe,
    // system side
    output logic wakeup_frame_sync,
    output logic audio_irq,
    output logic tx_dma_req,
    output logic rx_dma_req
);
    typedef struct packed {
        asi_gcfg_type gcfg;
        asi_cctl_type cctl;
        asi_dirctl_type txc;
        asi_dirctl_type rxc;
        logic [2:0] txclk_s;
        logic [2:0] txfs_s;
        logic [2:0] rxclk_s;
        logic [2:0] rxfs_s;
        logic [1:0] rxd_s;
        logic [7:0] psc_cnt;
        logic bclk;
        logic [6:0] fcnt;
        logic fs;
        logic tx_fs_seen;
        logic rx_fs_seen;
        asi_shift_type tx_state;
        logic [4:0] tx_cnt;
        logic [15:0] tx_sr;
        logic [15:0] tx_word;
        logic [15:0] tx_dma;
        logic tx_dma_full;
        asi_shift_type rx_state;
        logic [4:0] rx_cnt;
        logic [15:0] rx_sr;
        logic [15:0] rx_dma;
        logic rx_dma_full;
        logic [3:0] pend;
        logic irq;
        logic txd_o;
        logic txd_oe;
        logic wake_fs;
        logic tx_req;
        logic rx_req;
        logic pin_oe;
        asi_apb_rsp_type rsp;
    } asi_top_state_type;

    asi_top_state_type st;
    asi_top_state_type next_st;
    logic tx_push, tx_pop, rx_push, rx_pop;
    logic tx_empty, tx_full, rx_empty, rx_full;
    logic [15:0] tx_rd_data, rx_rd_data, word, rx_new;
    logic [4:0] tx_count, rx_count, wlen, fs_len;
    logic [7:0] half;
    logic src_tick, int_rise, int_fall, ext, rx_local;
    logic tx_rise, tx_fs, rx_rise, rx_fall, rx_fs;
    logic tx_start, rx_start, tx_done, rx_done;
    logic access, complete, tx_dma_wr;

    // ======================================================
    // decoding helpers
    function automatic logic [4:0] asi_sync_len(input asi_fsl_type code);
        case (code)
            ASI_FSL_6: asi_sync_len = `ASI_FSL_LEN_6;
            ASI_FSL_13: asi_sync_len = `ASI_FSL_LEN_13;
            ASI_FSL_14: asi_sync_len = `ASI_FSL_LEN_14;
            ASI_FSL_15: asi_sync_len = `ASI_FSL_LEN_15;
            default: asi_sync_len = `ASI_FSL_LEN_16;
        endcase
    endfunction

    function automatic logic asi_mapped(input logic [7:0] a);
        asi_mapped = a == `ASI_OFF_GCFG || a == `ASI_OFF_CCTL ||
            a == `ASI_OFF_ISTAT || a == `ASI_OFF_RXSC ||
            a == `ASI_OFF_TXSC || a == `ASI_OFF_TXFIFO ||
            a == `ASI_OFF_RXFIFO || a == `ASI_OFF_TXDMA ||
            a == `ASI_OFF_RXDMA;
    endfunction

    function automatic logic asi_msb(input logic [15:0] sr,
        input logic w16);
        asi_msb = w16 ? sr[15] : sr[7];
    endfunction

    // ======================================================
    // fifos, one per direction
    asi_fifo u_tx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .push(tx_push),
        .push_data(apb_req.pwdata[15:0]),
        .pop(tx_pop),
        .rd_data(tx_rd_data),
        .count(tx_count),
        .empty(tx_empty),
        .full(tx_full)
    );

    asi_fifo u_rx_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .push(rx_push),
        .push_data(rx_new),
        .pop(rx_pop),
        .rd_data(rx_rd_data),
        .count(rx_count),
        .empty(rx_empty),
        .full(rx_full)
    );

    // ======================================================
    // next state of the whole block
    always_comb
    begin
        next_st = st;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        tx_done = 1'b0;
        rx_done = 1'b0;
        tx_dma_wr = 1'b0;
        word = st.tx_word;
        rx_new = '0;
        int_rise = 1'b0;
        int_fall = 1'b0;
        wlen = st.gcfg.word16 ? `ASI_WLEN_16 : `ASI_WLEN_8;
        // pin synchronisers
        next_st.txclk_s = {st.txclk_s[1:0], tx_bit_clock_in};
        next_st.txfs_s = {st.txfs_s[1:0], tx_frame_sync_in};
        next_st.rxclk_s = {st.rxclk_s[1:0], rx_bit_clock};
        next_st.rxfs_s = {st.rxfs_s[1:0], rx_frame_sync};
        next_st.rxd_s = {st.rxd_s[0], serial_rx_data};

        // bit clock prescaler over the selected source
        src_tick = st.gcfg.clk_src ? pll_tick : aux_tick;
        half = {1'b0, st.cctl.bit_clock_divisor[7:1]} +
            {7'h00, st.cctl.bit_clock_divisor[0]};
        if (st.gcfg.enable && src_tick)
        begin
            if (st.psc_cnt == st.cctl.bit_clock_divisor)
                next_st.psc_cnt = '0;
            else
                next_st.psc_cnt = st.psc_cnt + 8'h01;
            int_rise = next_st.psc_cnt == 8'h00;
            int_fall = next_st.psc_cnt == half &&
                st.cctl.bit_clock_divisor != 8'h00;
        end
        if (int_rise)
            next_st.bclk = 1'b1;
        if (int_fall)
            next_st.bclk = 1'b0;

        // frame counter and internal frame sync level
        fs_len = st.gcfg.long_sync ?
            asi_sync_len(st.gcfg.frame_sync_length) : `ASI_FS_SHORT;
        if (int_rise)
        begin
            if (st.fcnt == st.cctl.frame_clock_divisor)
                next_st.fcnt = '0;
            else
                next_st.fcnt = st.fcnt + 7'h01;
            next_st.fs = next_st.fcnt < {2'b00, fs_len};
        end
        if (!st.gcfg.enable)
        begin
            next_st.psc_cnt = '0;
            next_st.fcnt = '0;
            next_st.bclk = 1'b0;
            next_st.fs = 1'b0;
        end

        // clock and sync source for each direction
        ext = st.gcfg.ext_clock;
        tx_rise = ext ? st.txclk_s[1] && !st.txclk_s[2] : int_rise;
        tx_fs = ext ? st.txfs_s[1] : next_st.fs;
        rx_local = ext && !st.gcfg.sync_mode;
        rx_rise = rx_local ? st.rxclk_s[1] && !st.rxclk_s[2] : tx_rise;
        rx_fall = rx_local ? !st.rxclk_s[1] && st.rxclk_s[2] :
            (ext ? !st.txclk_s[1] && st.txclk_s[2] : int_fall);
        rx_fs = rx_local ? st.rxfs_s[1] : tx_fs;
        if (tx_rise)
            next_st.tx_fs_seen = tx_fs;
        if (rx_rise)
            next_st.rx_fs_seen = rx_fs;
        tx_start = st.gcfg.enable && tx_rise && tx_fs && !st.tx_fs_seen;
        rx_start = st.gcfg.enable && rx_rise && rx_fs && !st.rx_fs_seen;

        // register bus: capture read data, then act at completion
        access = apb_req.psel && apb_req.penable;
        complete = access && st.rsp.pready && asi_mapped(apb_req.paddr);
        next_st.rsp.pready = access && !st.rsp.pready;
        if (access && !st.rsp.pready)
        begin
            next_st.rsp.pslverr = !asi_mapped(apb_req.paddr);
            case (apb_req.paddr)
                `ASI_OFF_GCFG: next_st.rsp.prdata = st.gcfg;
                `ASI_OFF_CCTL: next_st.rsp.prdata = st.cctl;
                `ASI_OFF_ISTAT: next_st.rsp.prdata = {28'h0000000, st.pend};
                `ASI_OFF_RXSC: next_st.rsp.prdata =
                    {19'h00000, st.rx_dma_full, rx_count, st.rxc};
                `ASI_OFF_TXSC: next_st.rsp.prdata =
                    {19'h00000, st.tx_dma_full, tx_count, st.txc};
                `ASI_OFF_RXFIFO: next_st.rsp.prdata = {16'h0000, rx_rd_data};
                `ASI_OFF_TXDMA: next_st.rsp.prdata = {16'h0000, st.tx_dma};
                `ASI_OFF_RXDMA: next_st.rsp.prdata = {16'h0000, st.rx_dma};
                default: next_st.rsp.prdata = '0;
            endcase
        end
        if (complete && apb_req.pwrite)
        begin
            case (apb_req.paddr)
                `ASI_OFF_GCFG:
                begin
                    next_st.gcfg = asi_gcfg_type'(apb_req.pwdata);
                    next_st.gcfg.rsvd = '0;
                end
                `ASI_OFF_CCTL:
                begin
                    next_st.cctl = asi_cctl_type'(apb_req.pwdata);
                    next_st.cctl.rsvd = '0;
                end
                `ASI_OFF_RXSC:
                begin
                    next_st.rxc.limit = apb_req.pwdata[6:3];
                    next_st.rxc.err_ie = apb_req.pwdata[2];
                    next_st.rxc.warn_ie = apb_req.pwdata[1];
                    if (apb_req.pwdata[`ASI_SC_FLAG_BIT])
                        next_st.rxc.err_flag = 1'b0;
                end
                `ASI_OFF_TXSC:
                begin
                    next_st.txc.limit = apb_req.pwdata[6:3];
                    next_st.txc.err_ie = apb_req.pwdata[2];
                    next_st.txc.warn_ie = apb_req.pwdata[1];
                    if (apb_req.pwdata[`ASI_SC_FLAG_BIT])
                        next_st.txc.err_flag = 1'b0;
                end
                `ASI_OFF_TXFIFO: tx_push = 1'b1;
                `ASI_OFF_TXDMA:
                begin
                    next_st.tx_dma = apb_req.pwdata[15:0];
                    next_st.tx_dma_full = 1'b1;
                    tx_dma_wr = 1'b1;
                end
                default: ;
            endcase
        end
        if (complete && !apb_req.pwrite)
        begin
            if (apb_req.paddr == `ASI_OFF_RXFIFO)
                rx_pop = 1'b1;
            if (apb_req.paddr == `ASI_OFF_RXDMA)
                next_st.rx_dma_full = 1'b0;
        end

        // transmit shifter, started by each frame sync
        unique case (st.tx_state)
            ASI_IDLE:
                if (tx_start)
                begin
                    next_st.tx_state = ASI_SHIFT;
                    next_st.txd_o = asi_msb(st.tx_sr, st.gcfg.word16);
                    next_st.txd_oe = 1'b1;
                    next_st.tx_sr = st.tx_sr << 1;
                    next_st.tx_cnt = 5'h01;
                end
            ASI_SHIFT:
                if (tx_rise)
                begin
                    if (st.tx_cnt == wlen)
                    begin
                        next_st.tx_state = ASI_IDLE;
                        next_st.txd_oe = 1'b0;
                        tx_done = 1'b1;
                    end
                    else
                    begin
                        next_st.txd_o = asi_msb(st.tx_sr, st.gcfg.word16);
                        next_st.tx_sr = st.tx_sr << 1;
                        next_st.tx_cnt = st.tx_cnt + 5'h01;
                    end
                end
        endcase

        // reload the next transmit word after each completed one
        if (tx_done)
        begin
            if (st.gcfg.tx_slot0_dma_select)
            begin
                if (st.tx_dma_full)
                begin
                    word = st.tx_dma;
                    if (!tx_dma_wr)
                        next_st.tx_dma_full = 1'b0;
                end
            end
            else if (!tx_empty)
            begin
                word = tx_rd_data;
                tx_pop = 1'b1;
            end
            else
            begin
                next_st.txc.err_flag = 1'b1;
            end
            next_st.tx_sr = word;
            next_st.tx_word = word;
            // a sync on the closing edge starts the next word at once
            if (tx_start)
            begin
                next_st.tx_state = ASI_SHIFT;
                next_st.txd_o = asi_msb(word, st.gcfg.word16);
                next_st.txd_oe = 1'b1;
                next_st.tx_sr = word << 1;
                next_st.tx_cnt = 5'h01;
            end
        end

        // receive shifter, sampling after the frame sync
        unique case (st.rx_state)
            ASI_IDLE:
                if (rx_start)
                begin
                    next_st.rx_state = ASI_SHIFT;
                    next_st.rx_cnt = '0;
                end
            ASI_SHIFT:
                if (rx_fall)
                begin
                    next_st.rx_sr = {st.rx_sr[14:0], st.rxd_s[1]};
                    next_st.rx_cnt = st.rx_cnt + 5'h01;
                    if (next_st.rx_cnt == wlen)
                    begin
                        next_st.rx_state = ASI_IDLE;
                        rx_done = 1'b1;
                    end
                end
        endcase

        // hand the completed word to dma register or fifo
        rx_new = st.gcfg.word16 ? next_st.rx_sr :
            {8'h00, next_st.rx_sr[7:0]};
        if (rx_done)
        begin
            if (st.gcfg.rx_slot0_dma_select)
            begin
                next_st.rx_dma = rx_new;
                next_st.rx_dma_full = 1'b1;
            end
            else if (!rx_full)
                rx_push = 1'b1;
            else
                next_st.rxc.err_flag = 1'b1;
        end

        if (!st.gcfg.enable)
        begin
            next_st.tx_state = ASI_IDLE;
            next_st.rx_state = ASI_IDLE;
            next_st.txd_oe = 1'b0;
        end

        // pending flags and the merged interrupt line
        next_st.pend[`ASI_IST_RXE_BIT] = st.rxc.err_ie && st.rxc.err_flag;
        next_st.pend[`ASI_IST_RXP_BIT] = st.rxc.warn_ie &&
            !st.gcfg.rx_slot0_dma_select && !st.rxc.err_flag &&
            rx_count > {1'b0, st.rxc.limit};
        next_st.pend[`ASI_IST_TXE_BIT] = st.txc.err_ie && st.txc.err_flag;
        next_st.pend[`ASI_IST_TXP_BIT] = st.txc.warn_ie &&
            !st.gcfg.tx_slot0_dma_select && !st.txc.err_flag &&
            tx_count <= {1'b0, st.txc.limit};
        next_st.irq = |next_st.pend;

        // pin and request outputs
        next_st.wake_fs = tx_fs;
        next_st.tx_req = st.gcfg.enable && st.gcfg.tx_slot0_dma_select &&
            !next_st.tx_dma_full;
        next_st.rx_req = st.gcfg.rx_slot0_dma_select &&
            next_st.rx_dma_full;
        next_st.pin_oe = next_st.gcfg.enable && !next_st.gcfg.ext_clock;
    end

    // ======================================================
    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.gcfg <= `ASI_RST_GCFG;
            st.cctl <= `ASI_RST_CCTL;
            st.txc.limit <= `ASI_RST_LIMIT;
            st.rxc.limit <= `ASI_RST_LIMIT;
        end
        else
            st <= next_st;
    end

    // outputs straight from state
    assign apb_rsp = st.rsp;
    assign tx_bit_clock_out = st.bclk;
    assign tx_bit_clock_oe = st.pin_oe;
    assign tx_frame_sync_out = st.fs;
    assign tx_frame_sync_oe = st.pin_oe;
    assign serial_tx_data = st.txd_o;
    assign serial_tx_data_oe = st.txd_oe;
    assign wakeup_frame_sync = st.wake_fs;
    assign audio_irq = st.irq;
    assign tx_dma_req = st.tx_req;
    assign rx_dma_req = st.rx_req;
endmodule
`default_nettype wire

// file: tb/asi_top_props.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// port checker
module asi_props
    import asi_pkg::*;
(
    // clock, reset and bus
    input wire logic clk,
    input wire logic rst_n,
    input wire asi_apb_req_type apb_req,
    input wire asi_apb_rsp_type apb_rsp,
    // serial pins
    input wire logic tx_bit_clock_out,
    input wire logic tx_bit_clock_oe,
    input wire logic tx_frame_sync_out,
    input wire logic tx_frame_sync_oe,
    input wire logic serial_tx_data,
    input wire logic serial_tx_data_oe,
    input wire logic wakeup_frame_sync
);
    logic [4:0] bits;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // bit clock rises seen while a word is out
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n)
            bits <= 5'h00;
        else
            bits <= serial_tx_data_oe ?
                bits + 5'($rose(tx_bit_clock_out)) : 5'h00;
    ready_once_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready too long");
    ready_wait_a: assert property (apb_req.psel && apb_req.penable
        && !apb_rsp.pready |=> apb_rsp.pready) else $error("no pready");
    refuse_zero_a: assert property (apb_rsp.pready && apb_rsp.pslverr
        |-> apb_rsp.prdata == 32'h0) else $error("refused data");
    word_len_a: assert property ($fell(serial_tx_data_oe)
        && tx_bit_clock_oe |-> bits == 5'h10 || bits == 5'h08)
        else $error("word length");
    shift_edge_a: assert property ($changed(serial_tx_data)
        && $past(serial_tx_data_oe) && serial_tx_data_oe && tx_bit_clock_oe
        |-> $rose(tx_bit_clock_out)) else $error("data off edge");
    start_sync_a: assert property ($rose(serial_tx_data_oe)
        && tx_frame_sync_oe |-> tx_frame_sync_out || $past(tx_frame_sync_out))
        else $error("word without sync");
    oe_pair_a: assert property (tx_bit_clock_oe == tx_frame_sync_oe)
        else $error("oe differ");
    wake_copy_a: assert property ($rose(tx_frame_sync_out)
        && tx_frame_sync_oe |-> ##[0:2] wakeup_frame_sync)
        else $error("wakeup missed");
    word_end_c: cover property ($fell(serial_tx_data_oe));
    refused_c: cover property (apb_rsp.pready && apb_rsp.pslverr);
    sync_c: cover property ($rose(tx_frame_sync_out));
endmodule
`default_nettype wire

// file: tb/asi_codec.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// codec model
module asi_codec
(
    // serial pins
    input wire logic bit_clock,
    input wire logic data_in,
    input wire logic data_oe,
    output logic data_out = 1'b0,
    // received words
    output logic [15:0] hist [32],
    output logic [7:0] words = 8'h00
);
    logic [15:0] sh = 16'h0000;
    logic [4:0] n = 5'h00;
    // take driven bits on the falling clock, msb first
    always @(negedge bit_clock)
    begin
        sh = {sh[14:0], data_in};
        n = data_oe ? n + 5'h01 : 5'h00;
        if (n == 5'h10)
        begin
            hist[words[4:0]] <= sh;
            words <= words + 8'h01;
            n = 5'h00;
        end
    end
    // reply with a level that flips every bit
    always @(posedge bit_clock)
        data_out <= ~data_out;
endmodule
`default_nettype wire

// file: tb/asi_top_test.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// bus and serial bench
module asi_top_test
    import asi_pkg::*;
;
    logic clk, rst_n, aux_tick, serial_rx_data, audio_irq;
    logic tx_bit_clock_out, tx_bit_clock_oe, tx_frame_sync_out;
    logic tx_frame_sync_oe, serial_tx_data, serial_tx_data_oe;
    logic wakeup_frame_sync;
    logic [15:0] hist [32];
    logic [7:0] words;
    int errors, comparisons, t;
    asi_apb_req_type apb_req;
    asi_apb_rsp_type apb_rsp;
    // device with external clock pins idle
    asi_top dut (
        .clk, .rst_n, .apb_req, .apb_rsp, .aux_tick, .pll_tick(1'b0),
        .tx_bit_clock_in(1'b0), .tx_bit_clock_out, .tx_bit_clock_oe,
        .tx_frame_sync_in(1'b0), .tx_frame_sync_out, .tx_frame_sync_oe,
        .rx_bit_clock(1'b0), .rx_frame_sync(1'b0), .serial_rx_data,
        .serial_tx_data, .serial_tx_data_oe, .wakeup_frame_sync,
        .audio_irq, .tx_dma_req(), .rx_dma_req()
    );
    asi_codec codec (
        .bit_clock(tx_bit_clock_out), .data_in(serial_tx_data),
        .data_oe(serial_tx_data_oe), .data_out(serial_rx_data), .hist, .words
    );
    // system clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // source tick every other cycle
    always @(posedge clk)
        aux_tick <= rst_n ? ~aux_tick : 1'b0;
    task automatic check(input logic [31:0] seen, exp, input string what);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, input string what);
        int n;
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        apb_req.penable <= 1'b1;
        for (n = 0; n < 50 && apb_rsp.pready !== 1'b1; n++)
            @(posedge clk);
        if (!w)
        begin
            check(apb_rsp.prdata, d, what);
            check({31'h0, apb_rsp.pslverr}, {31'h0, a > 8'h20}, what);
        end
        apb_req <= '0;
        @(posedge clk);
        if (n == 50)
            test_done(1);
    endtask
    task automatic test_done(input int stuck);
        errors += stuck;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        errors = 0;
        comparisons = 0;
        rst_n = 1'b0;
        apb_req = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(1'b0, 8'h04, 32'h0F01, "ctl");
        bus(1'b0, 8'h24, 32'h0, "hole");
        bus(1'b1, 8'h14, 32'hA5C3, "");
        bus(1'b1, 8'h14, 32'h5A3C, "");
        bus(1'b0, 8'h10, 32'h140, "txsc");
        bus(1'b1, 8'h04, 32'h1103, "");
        bus(1'b1, 8'h00, 32'h9, "");
        for (t = 0; t < 5000 && words < 8'h14; t++)
            @(posedge clk);
        if (t == 5000)
            test_done(1);
        check({16'h0, hist[1]}, 32'hA5C3, "w1");
        check({16'h0, hist[2]}, 32'h5A3C, "w2");
        check({16'h0, hist[3]}, 32'h5A3C, "w3");
        bus(1'b0, 8'h10, 32'h41, "txsc");
        bus(1'b0, 8'h0C, 32'h841, "rxsc");
        bus(1'b0, 8'h18, 32'h5555, "rxfifo");
        bus(1'b1, 8'h10, 32'h44, "");
        bus(1'b0, 8'h08, 32'h4, "istat");
        check({31'h0, audio_irq}, 32'h1, "irq");
        bus(1'b1, 8'h10, 32'h40, "");
        @(negedge clk);
        check({31'h0, audio_irq}, 32'h0, "irq");
        test_done(0);
    end
endmodule
bind asi_top asi_props props (
    .clk, .rst_n, .apb_req, .apb_rsp, .tx_bit_clock_out, .tx_bit_clock_oe,
    .tx_frame_sync_out, .tx_frame_sync_oe, .serial_tx_data,
    .serial_tx_data_oe, .wakeup_frame_sync
);
`default_nettype wire
